// ### rtl/vic_pkg.sv
// Summary of operation
// - drive active-low normal and fast requests
// - source 0 is the fast external input
// - source 1 is the system-peripheral group
// - other sources maskable and vectored
// - internal sources edge or level detect
// - external sources rising/falling/high/low detect
// - eight priority levels pick normal request
// - higher priority nests over serviced one
// - one 32-bit vector per source
// - vector read returns current source vector
// - protect mode stops read side effects
// - fast forcing routes sources to fast line
// - general mask blocks lines, keeps events
// - peripheral id maps to source number
package vic_pkg;
    localparam int VIC_NSRC = 32;
    localparam int VIC_NSYS = 8;
    localparam int VIC_NLVL = 8;
    localparam int VIC_PRIO_W = 3;
    localparam int VIC_MODE_W = 2;
    localparam int VIC_AW = 8;
    localparam logic [4:0] VIC_SRC_FAST = 5'h00;
    localparam logic [4:0] VIC_SRC_SYS = 5'h01;
    localparam logic [4:0] VIC_SRC_EXT0 = 5'h1E;
    localparam logic [4:0] VIC_SRC_EXT1 = 5'h1F;
    localparam logic [VIC_NSRC-1:0] VIC_EXT_MASK = 32'hC000_0001;
    // word indexes; byte address = index * 4
    localparam logic [VIC_AW-1:0] VIC_IDX_SMR0 = 8'h00;
    localparam logic [VIC_AW-1:0] VIC_IDX_SVR0 = 8'h20;
    localparam logic [VIC_AW-1:0] VIC_IDX_IVR = 8'h40;
    localparam logic [VIC_AW-1:0] VIC_IDX_ISR = 8'h41;
    localparam logic [VIC_AW-1:0] VIC_IDX_IPR = 8'h42;
    localparam logic [VIC_AW-1:0] VIC_IDX_IMR = 8'h43;
    localparam logic [VIC_AW-1:0] VIC_IDX_IECR = 8'h44;
    localparam logic [VIC_AW-1:0] VIC_IDX_IDCR = 8'h45;
    localparam logic [VIC_AW-1:0] VIC_IDX_ICCR = 8'h46;
    localparam logic [VIC_AW-1:0] VIC_IDX_EOICR = 8'h47;
    localparam logic [VIC_AW-1:0] VIC_IDX_FFER = 8'h48;
    localparam logic [VIC_AW-1:0] VIC_IDX_CTRL = 8'h49;
    localparam logic [VIC_AW-1:0] VIC_IDX_EVST = 8'h4A;
    localparam logic [VIC_AW-1:0] VIC_IDX_EVMSK = 8'h4B;
    localparam int VIC_CTRL_PROT = 0;
    localparam int VIC_CTRL_GMSK = 1;
    localparam int VIC_SMR_MODE_LSB = 5;
    localparam int VIC_EV_NIRQ = 0;
    localparam int VIC_EV_NFIQ = 1;
    localparam int VIC_EV_W = 2;
    localparam logic [31:0] VIC_UNMAPPED = 32'h0000_0000;
    // mode: 0 low level, 1 falling, 2 high level, 3 rising
    typedef enum logic [1:0] {
        VIC_LOW_LEVEL,
        VIC_FALL_EDGE,
        VIC_HIGH_LEVEL,
        VIC_RISE_EDGE
    } vic_mode_t;
endpackage

// ### rtl/vic_detect.sv
`timescale 1ns/100ps
module vic_detect #(
    parameter int NSRC = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // sources
    input wire logic [NSRC-1:0] src_in,
    input wire logic [NSRC-1:0] ext_src,
    input wire logic [NSRC*2-1:0] mode,
    input wire logic [NSRC-1:0] clr,
    // pending view
    output logic [NSRC-1:0] pending
);
    import vic_pkg::*;
    if (NSRC < 1) begin : g_bad_cfg
        $error("vic_detect: unsupported source count");
    end
    logic [NSRC-1:0] prev_r;
    logic [NSRC-1:0] latch_r;
    // ==============================
    // per source detection
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_r <= '0;
        end else begin
            prev_r <= src_in;
        end
    end
    genvar i;
    generate
        for (i = 0; i < NSRC; i++) begin : g_src
            logic [1:0] m;
            logic edge_hit;
            logic level_val;
            // internal sources ignore polarity: only edge/level choice
            assign m = ext_src[i] ? mode[i*2 +: 2] : {1'b1, mode[i*2]};
            assign edge_hit = m[1] ? (src_in[i] & ~prev_r[i]) : (~src_in[i] & prev_r[i]);
            assign level_val = m[1] ? src_in[i] : ~src_in[i];
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    latch_r[i] <= 1'b0;
                end else if (m[0] && edge_hit) begin
                    latch_r[i] <= 1'b1;
                end else if (clr[i]) begin
                    latch_r[i] <= 1'b0;
                end
            end
            assign pending[i] = m[0] ? latch_r[i] : level_val;
        end
    endgenerate
endmodule

// ### rtl/vic_prio.sv
`timescale 1ns/100ps
module vic_prio #(
    parameter int NSRC = 32,
    parameter int PW = 3
) (
    // candidates
    input wire logic [NSRC-1:0] cand,
    input wire logic [NSRC*PW-1:0] prio,
    // winner
    output logic found,
    output logic [4:0] win_id,
    output logic [PW-1:0] win_prio
);
    import vic_pkg::*;
    // the winner id is five bits wide
    if (NSRC < 1 || NSRC > VIC_NSRC || PW < 1) begin : g_bad_cfg
        $error("vic_prio: unsupported parameters");
    end
    // lowest number wins among equals
    always_comb begin
        found = 1'b0;
        win_id = '0;
        win_prio = '0;
        for (int k = NSRC - 1; k >= 0; k--) begin
            if (cand[k] && (!found || prio[k*PW +: PW] >= win_prio)) begin
                found = 1'b1;
                win_id = 5'(k);
                win_prio = prio[k*PW +: PW];
            end
        end
    end
endmodule

// ### rtl/vic_top.sv
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module vic_top #(
    parameter int NSRC = vic_pkg::VIC_NSRC,
    parameter int NSYS = vic_pkg::VIC_NSYS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [vic_pkg::VIC_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // interrupt sources
    input wire logic external_input_fast,
    input wire logic [NSYS-1:0] system_peripheral_group,
    input wire logic [NSRC-1:0] periph_irq,
    input wire logic external_input_zero,
    input wire logic external_input_one,
    // processor lines
    output logic nirq_n,
    output logic nfiq_n,
    // event interrupt
    output logic evt_irq
);
    import vic_pkg::*;
    // the source map and the five-bit source id assume the full source count
    if (NSRC != VIC_NSRC || NSYS < 1) begin : g_bad_cfg
        $error("vic_top: unsupported source count");
    end

    // ==============================
    // source map
    logic [NSRC-1:0] src_raw;
    logic sys_any;
    // group lines come from this clock domain, so no synchroniser
    assign sys_any = |system_peripheral_group;
    always_comb begin
        src_raw = periph_irq;
        src_raw[VIC_SRC_FAST] = external_input_fast;
        src_raw[VIC_SRC_SYS] = sys_any;
        src_raw[VIC_SRC_EXT0] = external_input_zero;
        src_raw[VIC_SRC_EXT1] = external_input_one;
    end

    // ==============================
    // registers
    logic [31:0] vec_r [NSRC];
    logic [VIC_PRIO_W-1:0] prio_r [NSRC];
    logic [VIC_MODE_W-1:0] mode_r [NSRC];
    logic [NSRC-1:0] en_r;
    logic [NSRC-1:0] ff_r;
    logic prot_r;
    logic gmsk_r;
    logic [VIC_EV_W-1:0] evst_r;
    logic [VIC_EV_W-1:0] evmsk_r;
    logic [31:0] rdata_r;
    logic ack_r;
    // nesting stack of levels, top at depth - 1
    logic [VIC_PRIO_W-1:0] stk_prio_r [VIC_NLVL];
    logic [4:0] stk_id_r [VIC_NLVL];
    logic [3:0] depth_r;
    logic [4:0] cur_id_r;

    function automatic logic hit(input logic [VIC_AW-1:0] a, input logic [VIC_AW-1:0] b);
        hit = (a == b);
    endfunction

    logic wr;
    logic rd;
    assign wr = avs_write && !ack_r;
    assign rd = avs_read && !ack_r;
    // ==============================
    // bus handshake
    // accesses act at the first edge; the second edge only ends the wait
    // one wait cycle, then the answer
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    // byte lanes only matter for vectors; other registers take the word
    logic [31:0] wmask;
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
        end
    end

    // ==============================
    // detection and selection
    logic [NSRC*2-1:0] mode_flat;
    logic [NSRC*VIC_PRIO_W-1:0] prio_flat;
    logic [NSRC-1:0] clr_edge;
    logic [NSRC-1:0] pending;
    logic [NSRC-1:0] normal_cand;
    logic found;
    logic [4:0] win_id;
    logic [VIC_PRIO_W-1:0] win_prio;
    logic fiq_req;
    logic irq_req;
    logic ivr_read;
    logic eoi_write;
    logic ivr_write;
    logic iccr_write;
    logic evst_write;
    logic [NSRC-1:0] fast_bit;
    logic [2:0] top_idx;
    logic [VIC_PRIO_W-1:0] top_prio;
    logic [31:0] ivr_value;
    always_comb begin
        for (int k = 0; k < NSRC; k++) begin
            mode_flat[k*2 +: 2] = mode_r[k];
            prio_flat[k*VIC_PRIO_W +: VIC_PRIO_W] = prio_r[k];
        end
    end

    // only the external inputs get the four-way polarity choice
    vic_detect #(.NSRC(NSRC)) u_det (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .src_in(src_raw),
        .ext_src(VIC_EXT_MASK),
        .mode(mode_flat),
        .clr(clr_edge),
        .pending(pending)
    );

    // source 0 only ever reaches the fast line, whatever its priority field says
    assign fast_bit = NSRC'(1) << VIC_SRC_FAST;
    // fast source and forced sources skip the priority path
    assign normal_cand = pending & en_r & ~ff_r & ~fast_bit;
    // equal priorities: the lower source number wins
    vic_prio #(.NSRC(NSRC), .PW(VIC_PRIO_W)) u_prio (
        .cand(normal_cand),
        .prio(prio_flat),
        .found(found),
        .win_id(win_id),
        .win_prio(win_prio)
    );

    assign fiq_req = |(pending & en_r & (ff_r | fast_bit));
    // level of the service in progress; only used while depth is non-zero
    assign top_idx = 3'(depth_r - 4'h1);
    assign top_prio = stk_prio_r[top_idx];
    // only strictly higher than the level in service nests
    assign irq_req = found && (depth_r == 4'h0 || win_prio > top_prio);
    assign ivr_read = rd && hit(avs_address, VIC_IDX_IVR) && !prot_r;
    assign ivr_write = wr && hit(avs_address, VIC_IDX_IVR);
    assign iccr_write = wr && hit(avs_address, VIC_IDX_ICCR);
    assign evst_write = wr && hit(avs_address, VIC_IDX_EVST);
    assign eoi_write = wr && hit(avs_address, VIC_IDX_EOICR);
    // winner while a request stands, else the source in service
    assign ivr_value = irq_req ? vec_r[win_id] : vec_r[cur_id_r];

    // ==============================
    // processor lines and service state
    // registered so the core never sees a decode glitch
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nirq_n <= 1'b1;
            nfiq_n <= 1'b1;
        end else begin
            nirq_n <= ~(irq_req && !gmsk_r);
            nfiq_n <= ~(fiq_req && !gmsk_r);
        end
    end

    // in protect mode service entry is a write to the vector register
    logic enter;
    assign enter = irq_req && (ivr_read || (prot_r && ivr_write));
    // entries beyond the eighth level are dropped, so deeper nests go unserved
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            depth_r <= 4'h0;
            cur_id_r <= 5'h00;
            for (int k = 0; k < VIC_NLVL; k++) begin
                stk_prio_r[k] <= '0;
                stk_id_r[k] <= '0;
            end
        end else if (enter && depth_r < 4'(VIC_NLVL)) begin
            stk_prio_r[depth_r[2:0]] <= win_prio;
            stk_id_r[depth_r[2:0]] <= win_id;
            depth_r <= depth_r + 4'h1;
            cur_id_r <= win_id;
        end else if (eoi_write && depth_r != 4'h0) begin
            depth_r <= depth_r - 4'h1;
            cur_id_r <= (depth_r > 4'h1) ? stk_id_r[3'(depth_r - 4'h2)] : 5'h00;
        end
    end

    // acknowledged edge source is cleared; iccr clears any edge
    always_comb begin
        clr_edge = '0;
        if (enter) begin
            clr_edge[win_id] = 1'b1;
        end
        if (iccr_write) begin
            clr_edge = clr_edge | avs_writedata;
        end
    end

    // ==============================
    // register writes
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int k = 0; k < NSRC; k++) begin
                vec_r[k] <= '0;
                prio_r[k] <= '0;
                mode_r[k] <= '0;
            end
        end else if (wr) begin
            for (int k = 0; k < NSRC; k++) begin
                if (hit(avs_address, VIC_IDX_SMR0 + VIC_AW'(k))) begin
                    prio_r[k] <= avs_writedata[VIC_PRIO_W-1:0];
                    mode_r[k] <= avs_writedata[VIC_SMR_MODE_LSB +: VIC_MODE_W];
                end
                if (hit(avs_address, VIC_IDX_SVR0 + VIC_AW'(k))) begin
                    vec_r[k] <= (vec_r[k] & ~wmask) | (avs_writedata & wmask);
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_r <= '0;
            ff_r <= '0;
            prot_r <= 1'b0;
            gmsk_r <= 1'b0;
            evmsk_r <= '0;
        end else if (wr) begin
            if (hit(avs_address, VIC_IDX_IECR)) begin
                en_r <= en_r | avs_writedata;
            end else if (hit(avs_address, VIC_IDX_IDCR)) begin
                en_r <= en_r & ~avs_writedata;
            end else if (hit(avs_address, VIC_IDX_FFER)) begin
                ff_r <= avs_writedata & ~(NSRC'(1) << VIC_SRC_FAST);
            end else if (hit(avs_address, VIC_IDX_CTRL)) begin
                prot_r <= avs_writedata[VIC_CTRL_PROT];
                gmsk_r <= avs_writedata[VIC_CTRL_GMSK];
            end else if (hit(avs_address, VIC_IDX_EVMSK)) begin
                evmsk_r <= avs_writedata[VIC_EV_W-1:0];
            end
        end
    end

    // ==============================
    // events: requests recorded even under the general mask
    logic [VIC_EV_W-1:0] ev_set;
    assign ev_set = {fiq_req, irq_req};
    // a request in the cycle of its clear keeps the bit set
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            evst_r <= '0;
        end else if (evst_write) begin
            evst_r <= (evst_r & ~avs_writedata[VIC_EV_W-1:0]) | ev_set;
        end else begin
            evst_r <= evst_r | ev_set;
        end
    end
    assign evt_irq = |(evst_r & evmsk_r);

    // ==============================
    // reads
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else if (rd) begin
            // anything not decoded below reads as zero
            rdata_r <= VIC_UNMAPPED;
            if (avs_address < VIC_IDX_SVR0) begin
                rdata_r <= {25'h0, mode_r[avs_address[4:0]], 2'b00,
                            prio_r[avs_address[4:0]]};
            end else if (avs_address < VIC_IDX_IVR) begin
                rdata_r <= vec_r[avs_address[4:0]];
            end else if (hit(avs_address, VIC_IDX_IVR)) begin
                rdata_r <= ivr_value;
            end else if (hit(avs_address, VIC_IDX_ISR)) begin
                rdata_r <= {27'h0, cur_id_r};
            end else if (hit(avs_address, VIC_IDX_IPR)) begin
                rdata_r <= pending;
            end else if (hit(avs_address, VIC_IDX_IMR)) begin
                rdata_r <= en_r;
            end else if (hit(avs_address, VIC_IDX_FFER)) begin
                rdata_r <= ff_r;
            end else if (hit(avs_address, VIC_IDX_CTRL)) begin
                rdata_r <= {30'h0, gmsk_r, prot_r};
            end else if (hit(avs_address, VIC_IDX_EVST)) begin
                rdata_r <= {30'h0, evst_r};
            end else if (hit(avs_address, VIC_IDX_EVMSK)) begin
                rdata_r <= {30'h0, evmsk_r};
            end
        end
    end
    assign avs_readdata = rdata_r;
endmodule

// ### test/vic_chk.sv
`timescale 1ns/100ps
module vic_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // bus
    input wire logic [vic_pkg::VIC_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // lines
    input wire logic nirq_n,
    input wire logic nfiq_n,
    input wire logic evt_irq
);
    import vic_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // ====================
    // general mask mirror, follows accepted control writes
    logic gmsk_r;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gmsk_r <= 1'b0;
        end else if (avs_write && !avs_waitrequest && avs_address == VIC_IDX_CTRL) begin
            gmsk_r <= avs_writedata[VIC_CTRL_GMSK];
        end
    end
    // ====================
    property p_idle_wait;
        !avs_read && !avs_write |-> !avs_waitrequest;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("wait while idle");
    property p_one_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("more than one wait cycle");
    property p_rd_wait;
        $rose(avs_read) |-> avs_waitrequest;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read answered without wait");
    property p_wr_wait;
        $rose(avs_write) |-> avs_waitrequest;
    endproperty
    a_wr_wait: assert property (p_wr_wait) else $error("write answered without wait");
    property p_rd_hold;
        !avs_read |=> $stable(avs_readdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address > VIC_IDX_EVMSK |-> avs_readdata == VIC_UNMAPPED;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rst_lines;
        $fell(sys_rst) |-> nirq_n && nfiq_n && !evt_irq;
    endproperty
    a_rst_lines: assert property (p_rst_lines) else $error("lines active after reset");
    property p_gmask;
        gmsk_r && $past(gmsk_r) |-> nirq_n && nfiq_n;
    endproperty
    a_gmask: assert property (p_gmask) else $error("request under general mask");
endmodule

bind vic_top vic_chk u_chk (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .nirq_n(nirq_n),
    .nfiq_n(nfiq_n),
    .evt_irq(evt_irq)
);

// ### test/vic_cpu_model.sv
`timescale 1ns/100ps
module vic_cpu_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // request lines
    input wire logic nirq_n,
    input wire logic nfiq_n,
    // requests the core has taken
    output logic irq_taken,
    output logic fiq_taken
);
    // core samples both active-low lines on its clock
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_taken <= 1'b0;
            fiq_taken <= 1'b0;
        end else begin
            irq_taken <= !nirq_n;
            fiq_taken <= !nfiq_n;
        end
    end
endmodule

// ### test/vectored_priority_interrupt_controller_test.sv
`timescale 1ns/100ps
module vectored_priority_interrupt_controller_test;
    import vic_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic wait_req;
    logic nirq_n;
    logic nfiq_n;
    logic evt_irq;
    logic irq_taken;
    logic fiq_taken;
    logic ext_fast = 1'b0;
    logic [7:0] sys_grp = 8'h00;
    logic [31:0] periph = 32'h0;
    logic ext0 = 1'b0;
    logic ext1 = 1'b0;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #10 ref_clk = ~ref_clk;

    vic_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd_en),
        .avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat),
        .avs_waitrequest(wait_req), .external_input_fast(ext_fast),
        .system_peripheral_group(sys_grp), .periph_irq(periph), .external_input_zero(ext0),
        .external_input_one(ext1), .nirq_n(nirq_n), .nfiq_n(nfiq_n), .evt_irq(evt_irq));
    vic_cpu_model u_cpu (.ref_clk(ref_clk), .sys_rst(sys_rst), .nirq_n(nirq_n),
        .nfiq_n(nfiq_n), .irq_taken(irq_taken), .fiq_taken(fiq_taken));

    // ====================
    task print_verdict;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            print_verdict();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // sampled at the falling edge, clear of the launching edge
    task chk_evt(input logic exp);
        @(negedge ref_clk);
        chk({31'h0, evt_irq}, {31'h0, exp});
        @(posedge ref_clk);
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        adr <= a;
        wr_en <= wr;
        rd_en <= !wr;
        wdat <= d;
        // waitrequest and read data are taken at the rising edge only
        do begin
            @(posedge ref_clk);
            n++;
        end while (wait_req !== 1'b0);
        chk(32'(n), 32'h2);
        q = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // waits a bounded time for the core to see the line level
    task line(input logic fiq, input logic exp);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while ((fiq ? fiq_taken : irq_taken) !== exp && n < 8);
        chk({31'h0, fiq ? fiq_taken : irq_taken}, {31'h0, exp});
        // hand back on a rising edge so callers drive inputs there
        @(posedge ref_clk);
    endtask
    task cfg(input logic [7:0] s, input logic [7:0] smr, input logic [31:0] vec);
        bus(1'b1, VIC_IDX_SMR0 + s, {24'h0, smr});
        bus(1'b1, VIC_IDX_SVR0 + s, vec);
        bus(1'b1, VIC_IDX_IECR, 32'h1 << s);
    endtask
    // ====================
    task t_reset;
        line(1'b0, 1'b0);
        line(1'b1, 1'b0);
        chk_evt(1'b0);
        rd(8'hFF, VIC_UNMAPPED);
        rd(VIC_IDX_EVST, 32'h0);
    endtask
    task t_nest;
        cfg(8'h05, 8'h03, 32'hA5A5_0005);
        cfg(8'h07, 8'h06, 32'h5A5A_0007);
        bus(1'b1, VIC_IDX_EVMSK, 32'h1);
        @(posedge ref_clk);
        periph[5] <= 1'b1;
        line(1'b0, 1'b1);
        chk_evt(1'b1);
        rd(VIC_IDX_IVR, 32'hA5A5_0005);
        rd(VIC_IDX_ISR, 32'h5);
        periph[7] <= 1'b1;
        line(1'b0, 1'b1);
        rd(VIC_IDX_IVR, 32'h5A5A_0007);
        bus(1'b1, VIC_IDX_EVMSK, 32'h0);
        chk_evt(1'b0);
        periph <= 32'h0;
        bus(1'b1, VIC_IDX_EOICR, 32'h0);
        bus(1'b1, VIC_IDX_EOICR, 32'h0);
        line(1'b0, 1'b0);
        bus(1'b1, VIC_IDX_EVST, 32'h3);
        rd(VIC_IDX_EVST, 32'h0);
    endtask
    task t_fast;
        cfg(8'h00, 8'h40, 32'h0);
        ext_fast <= 1'b1;
        line(1'b1, 1'b1);
        ext_fast <= 1'b0;
        line(1'b1, 1'b0);
        cfg(8'h1E, 8'h60, 32'h0);
        bus(1'b1, VIC_IDX_FFER, 32'h4000_0000);
        ext0 <= 1'b1;
        line(1'b1, 1'b1);
        ext0 <= 1'b0;
        bus(1'b1, VIC_IDX_ICCR, 32'h4000_0000);
        line(1'b1, 1'b0);
        cfg(8'h1F, 8'h20, 32'h0000_0031);
        ext1 <= 1'b1;
        @(posedge ref_clk);
        ext1 <= 1'b0;
        line(1'b0, 1'b1);
        rd(VIC_IDX_IVR, 32'h0000_0031);
        bus(1'b1, VIC_IDX_EOICR, 32'h0);
        line(1'b0, 1'b0);
    endtask
    task t_sys_protect;
        cfg(8'h01, 8'h02, 32'h0000_0011);
        sys_grp <= 8'h40;
        line(1'b0, 1'b1);
        rd(VIC_IDX_IVR, 32'h0000_0011);
        sys_grp <= 8'h00;
        bus(1'b1, VIC_IDX_EOICR, 32'h0);
        cfg(8'h09, 8'h21, 32'h0000_0099);
        periph[9] <= 1'b1;
        @(posedge ref_clk);
        periph[9] <= 1'b0;
        line(1'b0, 1'b1);
        bus(1'b1, VIC_IDX_CTRL, 32'h1);
        rd(VIC_IDX_IVR, 32'h0000_0099);
        rd(VIC_IDX_IPR, 32'h0000_0200);
        bus(1'b1, VIC_IDX_CTRL, 32'h0);
        rd(VIC_IDX_IVR, 32'h0000_0099);
        rd(VIC_IDX_IPR, 32'h0);
        bus(1'b1, VIC_IDX_EOICR, 32'h0);
        line(1'b0, 1'b0);
    endtask
    task t_gmask;
        bus(1'b1, VIC_IDX_CTRL, 32'h2);
        periph[5] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        line(1'b0, 1'b0);
        rd(VIC_IDX_IPR, 32'h0000_0020);
        bus(1'b1, VIC_IDX_CTRL, 32'h0);
        line(1'b0, 1'b1);
        bus(1'b1, VIC_IDX_IDCR, 32'h0000_0020);
        line(1'b0, 1'b0);
        periph[5] <= 1'b0;
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_nest();
        t_fast();
        t_sys_protect();
        t_gmask();
        print_verdict();
    end
endmodule
